// >>> verif/begs_far_model.sv
// far side: IDE drive wide indication and strap pull-ups on the pins
// assumes straps pull every released pin high
module begs_far_model (
    // drive side
    input  wire logic       wide_ok_i,
    input  wire logic       ide_sel_i,
    output logic            drive_wide_transfer_n_o,
    // pins
    input  wire logic [2:0] val_i,
    input  wire logic [2:0] oe_i,
    output logic [2:0]      pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // drive claims 16-bit only on cycles that select it
    assign drive_wide_transfer_n_o = !(wide_ok_i && ide_sel_i);
    // released pins float to the pull-up, never the last value
    assign pin_o = (val_i & oe_i) | ~oe_i;
endmodule

// >>> verif/buffer_enable_and_game_select_tb.sv
// self-checking bench for begs_top
// assumes begs_top and begs_far_model are compiled first
module buffer_enable_and_game_select_tb;
    import begs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // row: mode, address, {aen,ior_n,iow_n,dev,ide,wide_ok,pd}, {den_n,hen_n,shared}
    typedef struct packed {logic [1:0] m; logic [9:0] a; logic [6:0] c; logic [2:0] e;} begs_row_type;
    logic       clk_i, rst_b_i, aen, ior_n, iow_n, dev, ide, wide_ok, pd, wide_n;
    logic [1:0] mode;
    logic [9:0] addr;
    logic [2:0] val, oe, pin;
    int         n_fail, compares;
    begs_row_type rows [10] = '{
        '{2'h1, GAME_ADDR, 7'h10, 3'h6},
        '{2'h1, GAME_ADDR, 7'h50, 3'h7},
        '{2'h0, GAME_ADDR, 7'h11, 3'h6},
        '{2'h0, 10'h000, 7'h30, 3'h7},
        '{2'h2, IDE_DATA_ADDR, 7'h26, 3'h1},
        '{2'h3, IDE_DATA_ADDR, 7'h14, 3'h3},
        '{2'h2, 10'h1F7, 7'h16, 3'h3},
        '{2'h1, 10'h3F8, 7'h28, 3'h3},
        '{2'h3, GAME_ADDR, 7'h20, 3'h6},
        '{2'h2, GAME_ADDR, 7'h10, 3'h6}};
    begs_top begs_top_inst (.clk_i, .rst_b_i, .host_addr_i(addr), .host_aen_i(aen),
        .host_ior_n_i(ior_n), .host_iow_n_i(iow_n), .device_sel_i(dev), .ide_sel_i(ide),
        .drive_wide_transfer_n_i(wide_n), .cfg_mode_i(mode), .parallel_data_out_i(pd),
        .data_buffer_enable_n_o(val[2]), .data_buffer_enable_oe_o(oe[2]),
        .upper_byte_xcvr_enable_n_o(val[1]), .upper_byte_xcvr_enable_oe_o(oe[1]),
        .shared_pin_o(val[0]), .shared_pin_oe_o(oe[0]));
    begs_far_model begs_far_model_inst (.wide_ok_i(wide_ok), .ide_sel_i(ide),
        .drive_wide_transfer_n_o(wide_n), .val_i(val), .oe_i(oe), .pin_o(pin));
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // rows take 4 cycles each; generous margin
    initial begin
        #5000;
        n_fail++;
        end_of_test();
    end
    initial begin
        n_fail = 0;
        compares = 0;
        rst_b_i = 1'b0;
        {mode, addr, aen, ior_n, iow_n, dev, ide, wide_ok, pd} = '0;
        repeat (2) @(negedge clk_i);
        check({1'b0, oe}, 4'h0);
        check({1'b0, pin}, 4'h7);
        rst_b_i = 1'b1;
        // 3-edge sync latency, so one spare cycle before looking
        foreach (rows[i]) begin
            {mode, addr} = {rows[i].m, rows[i].a};
            {aen, ior_n, iow_n, dev, ide, wide_ok, pd} = rows[i].c;
            repeat (4) @(negedge clk_i);
            check({1'b0, oe}, 4'h7);
            check({1'b0, pin}, {1'b0, rows[i].e});
        end
        // reset again with strobes idle and a chip decode pending
        {aen, ior_n, iow_n, dev, ide, wide_ok, pd} = 7'h38;
        rst_b_i = 1'b0;
        @(negedge clk_i);
        check({1'b0, oe}, 4'h0);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        check({1'b0, oe}, 4'h7);
        check({1'b0, pin}, 4'h7);
        end_of_test();
    end
endmodule

// >>> verilog/begs_pkg.sv
// constants for the buffer enable / game select glue block
// assumes the address decode and drive-side signals arrive from pins
package begs_pkg;
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    localparam int          ADDR_W        = 10;
    localparam logic [9:0]  GAME_ADDR     = 10'h201;
    // default primary IDE data register
    localparam logic [9:0]  IDE_DATA_ADDR = 10'h1F0;
    // ----------------------------------------
    // configuration modes
    // ----------------------------------------
    localparam logic [1:0]  CFG_SOFT_MB   = 2'h0;
    localparam logic [1:0]  CFG_SOFT_AI   = 2'h1;
    localparam logic [1:0]  CFG_HARD_BAS  = 2'h2;
    localparam logic [1:0]  CFG_HARD_EXT  = 2'h3;
endpackage

// >>> verilog/begs_top.sv
// buffer enables, upper-byte transceiver enable and shared direction/game select pin
// assumes host bus strobes and address come from pins; isa_reset is synchronous, active low
//
// Contract
// - drive data buffer enable low for any host I/O access (aen low) to the device or IDE
// - data buffer enable gates the external ISA buffer for device and IDE I/O transfers only
// - during ISA reset all three pins are configuration inputs, not outputs
// - upper-byte enable asserted on IDE data register I/O only with drive wide
// - upper-byte enable is an output steering the high-byte transceiver
// - in soft motherboard mode the shared pin is parallel direction output
// - direction output low while parallel data drives, high while it receives
// - other modes make the shared pin game select, ignoring parallel direction
// - game select asserted low for any host I/O access at 201h
module begs_top (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    // host bus pins
    input  wire logic [begs_pkg::ADDR_W-1:0] host_addr_i,
    input  wire logic                       host_aen_i,
    input  wire logic                       host_ior_n_i,
    input  wire logic                       host_iow_n_i,
    // device decode and drive side
    input  wire logic                       device_sel_i,
    input  wire logic                       ide_sel_i,
    input  wire logic                       drive_wide_transfer_n_i,
    // configuration and parallel port state
    input  wire logic [1:0]                 cfg_mode_i,
    input  wire logic                       parallel_data_out_i,
    // pin drivers
    output logic                            data_buffer_enable_n_o,
    output logic                            data_buffer_enable_oe_o,
    output logic                            upper_byte_xcvr_enable_n_o,
    output logic                            upper_byte_xcvr_enable_oe_o,
    output logic                            shared_pin_o,
    output logic                            shared_pin_oe_o
);
    import begs_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two stages on the host bus and drive-wide inputs (not device_sel_i or ide_sel_i); stage one is read only by stage two
    localparam int SYN_W = ADDR_W + 4;
    // reset to the pins' idle levels (strobes high, wide high, aen low):
    // an all-zero reset would fake an I/O cycle on the first edges after release
    localparam logic [SYN_W-1:0] SYNC_IDLE = {{ADDR_W{1'b0}}, 4'h7};
    logic [SYN_W-1:0] sync1;
    logic [SYN_W-1:0] sync2;
    logic [SYN_W-1:0] next_sync1;
    logic [SYN_W-1:0] next_sync2;

    always_comb begin
        next_sync1 = {host_addr_i, host_aen_i, host_ior_n_i, host_iow_n_i, drive_wide_transfer_n_i};
        next_sync2 = sync1;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
        end
    end

    logic [ADDR_W-1:0] s_addr;
    logic              s_aen;
    logic              s_ior_n;
    logic              s_iow_n;
    logic              s_wide_n;
    assign {s_addr, s_aen, s_ior_n, s_iow_n, s_wide_n} = sync2;

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    logic io_cycle;
    logic next_den_n;
    logic next_hen_n;
    logic next_shared;
    logic next_oe;

    // dma cycles (aen high) are not host I/O to our decode
    assign io_cycle = !s_aen && (!s_ior_n || !s_iow_n);

    always_comb begin
        next_oe     = 1'b1;
        next_den_n  = !(io_cycle && (device_sel_i || ide_sel_i));
        next_hen_n  = !(io_cycle && (s_addr == IDE_DATA_ADDR) && !s_wide_n);
        if (cfg_mode_i == CFG_SOFT_MB) begin
            next_shared = !parallel_data_out_i;
        end else begin
            next_shared = !(io_cycle && (s_addr == GAME_ADDR));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            // pins released for strapping; idle levels parked high
            data_buffer_enable_n_o      <= 1'b1;
            upper_byte_xcvr_enable_n_o  <= 1'b1;
            shared_pin_o                <= 1'b1;
            data_buffer_enable_oe_o     <= 1'b0;
            upper_byte_xcvr_enable_oe_o <= 1'b0;
            shared_pin_oe_o             <= 1'b0;
        end else begin
            data_buffer_enable_n_o      <= next_den_n;
            upper_byte_xcvr_enable_n_o  <= next_hen_n;
            shared_pin_o                <= next_shared;
            data_buffer_enable_oe_o     <= next_oe;
            upper_byte_xcvr_enable_oe_o <= next_oe;
            shared_pin_oe_o             <= next_oe;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    oe_in_reset_a: assert property (@(posedge clk_i) !rst_b_i |=> !data_buffer_enable_oe_o
        && !upper_byte_xcvr_enable_oe_o && !shared_pin_oe_o)
        else $error("pins driven during reset");
    oe_after_rst_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $past(rst_b_i) |=> data_buffer_enable_oe_o && upper_byte_xcvr_enable_oe_o
        && shared_pin_oe_o)
        else $error("pins not driven after reset");
    den_assert_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        io_cycle && device_sel_i |=> !data_buffer_enable_n_o)
        else $error("data buffer enable missed");
    den_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !io_cycle |=> data_buffer_enable_n_o)
        else $error("data buffer enable outside access");
    hen_narrow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_wide_n |=> upper_byte_xcvr_enable_n_o)
        else $error("upper enable without wide drive");
    hen_wide_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        io_cycle && s_addr == IDE_DATA_ADDR && !s_wide_n |=> !upper_byte_xcvr_enable_n_o)
        else $error("upper enable missed");
    dir_track_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cfg_mode_i == CFG_SOFT_MB |=> shared_pin_o == !$past(parallel_data_out_i))
        else $error("direction mismatch");
    game_sel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cfg_mode_i != CFG_SOFT_MB && io_cycle && s_addr == GAME_ADDR |=> !shared_pin_o)
        else $error("game select missed");
    game_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cfg_mode_i != CFG_SOFT_MB && !io_cycle |=> shared_pin_o)
        else $error("game select spurious");

    // ----------------------------------------
    // checks: reset release
    // ----------------------------------------
    vals_in_reset_a: assert property (@(posedge clk_i) !rst_b_i |=> data_buffer_enable_n_o
        && upper_byte_xcvr_enable_n_o && shared_pin_o)
        else $error("pin values not parked during reset");
    sync_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> !io_cycle)
        else $error("false access after reset");
    oe_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> data_buffer_enable_oe_o && upper_byte_xcvr_enable_oe_o && shared_pin_oe_o)
        else $error("pin released in normal operation");

    // ----------------------------------------
    // checks: data buffer enable
    // ----------------------------------------
    den_dma_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_aen |=> data_buffer_enable_n_o)
        else $error("data buffer enable on dma cycle");
    den_ide_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        io_cycle && ide_sel_i |=> !data_buffer_enable_n_o)
        else $error("data buffer enable missed for drive");
    den_unsel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !device_sel_i && !ide_sel_i |=> data_buffer_enable_n_o)
        else $error("data buffer enable without decode");
    den_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !s_aen && !s_iow_n && device_sel_i |=> !data_buffer_enable_n_o)
        else $error("data buffer enable missed on write");
    den_both_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        io_cycle && device_sel_i && ide_sel_i |=> !data_buffer_enable_n_o)
        else $error("data buffer enable missed on dual decode");

    // ----------------------------------------
    // checks: upper-byte enable
    // ----------------------------------------
    hen_dma_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_aen |=> upper_byte_xcvr_enable_n_o)
        else $error("upper enable on dma cycle");
    hen_addr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_addr != IDE_DATA_ADDR |=> upper_byte_xcvr_enable_n_o)
        else $error("upper enable off data register");
    hen_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !io_cycle |=> upper_byte_xcvr_enable_n_o)
        else $error("upper enable outside access");
    hen_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !s_aen && !s_ior_n && s_addr == IDE_DATA_ADDR && !s_wide_n |=> !upper_byte_xcvr_enable_n_o)
        else $error("upper enable missed on read");

    // ----------------------------------------
    // checks: shared pin
    // ----------------------------------------
    game_dma_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cfg_mode_i != CFG_SOFT_MB && s_aen |=> shared_pin_o)
        else $error("game select on dma cycle");
    game_addr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cfg_mode_i != CFG_SOFT_MB && s_addr != GAME_ADDR |=> shared_pin_o)
        else $error("game select off its address");
    dir_out_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cfg_mode_i == CFG_SOFT_MB && parallel_data_out_i |=> !shared_pin_o)
        else $error("direction not low while driving");
    dir_in_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cfg_mode_i == CFG_SOFT_MB && !parallel_data_out_i |=> shared_pin_o)
        else $error("direction not high while receiving");
    dir_nogame_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cfg_mode_i == CFG_SOFT_MB && !parallel_data_out_i && io_cycle && s_addr == GAME_ADDR
        |=> shared_pin_o)
        else $error("game decode leaks into direction mode");

    // ----------------------------------------
    // covers
    // ----------------------------------------
    den_cov_c: cover property (@(posedge clk_i) !data_buffer_enable_n_o);
    rel_cov_c: cover property (@(posedge clk_i) $rose(rst_b_i));
    hen_cov_c: cover property (@(posedge clk_i) !upper_byte_xcvr_enable_n_o);
    game_cov_c: cover property (@(posedge clk_i) cfg_mode_i != CFG_SOFT_MB && !shared_pin_o);
    dir_cov_c: cover property (@(posedge clk_i) cfg_mode_i == CFG_SOFT_MB && !shared_pin_o);
endmodule
